// >>> design/fcsp_pkg.sv
/*
 * Constants and carrier types of the flash command, status and protection block.
 * Assumes a 32-bit APB register bus and a single 100 MHz clock.
 */
package fcsp_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FCSP_OFS_DIVIDER = 8'h00;
    localparam logic [7:0] FCSP_OFS_SECURE  = 8'h04;
    localparam logic [7:0] FCSP_OFS_CONFIG  = 8'h08;
    localparam logic [7:0] FCSP_OFS_PROTECT = 8'h0c;
    localparam logic [7:0] FCSP_OFS_STATUS  = 8'h10;
    localparam logic [7:0] FCSP_OFS_COMMAND = 8'h14;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam logic [7:0] FCSP_CONFIG_MASK  = 8'he0;
    localparam int         FCSP_KEY_EN_BIT   = 5;
    localparam int         FCSP_ST_BUF_EMPTY = 7;
    localparam int         FCSP_ST_COMPLETE  = 6;
    localparam int         FCSP_ST_PROT_VIOL = 5;
    localparam int         FCSP_ST_ACC_ERR   = 4;
    localparam int         FCSP_ST_BLANK     = 2;
    localparam int         FCSP_DIV_LOADED   = 7;

    // ------------------------------------------------------------
    // Reset values and fixed codes
    // ------------------------------------------------------------
    localparam logic [7:0]  FCSP_RST_CONFIG   = 8'h00;
    localparam logic [7:0]  FCSP_RST_PROTECT  = 8'hff;
    localparam logic [1:0]  FCSP_RST_SECURE   = 2'h3;
    localparam logic [1:0]  FCSP_SEC_UNSECURE = 2'h2;
    localparam logic [15:0] FCSP_KEY_LO       = 16'hffb0;
    localparam logic [15:0] FCSP_KEY_HI       = 16'hffb7;
    localparam int          FCSP_PAGE_BYTES   = 512;
    localparam int          FCSP_PAGE_SHIFT   = $clog2(FCSP_PAGE_BYTES);

    // ------------------------------------------------------------
    // Command codes and sequence states
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        FCSP_CMD_BLANK = 8'h05,
        FCSP_CMD_BYTE  = 8'h20,
        FCSP_CMD_BURST = 8'h25,
        FCSP_CMD_PAGE  = 8'h40,
        FCSP_CMD_MASS  = 8'h41
    } fcsp_cmd_t;

    typedef enum logic [1:0] {
        FCSP_SEQ_IDLE  = 2'b00,
        FCSP_SEQ_DATA  = 2'b01,
        FCSP_SEQ_CMD   = 2'b10
    } fcsp_seq_t;

    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] addr;
        logic [7:0]  data;
    } fcsp_op_t;

endpackage

// >>> design/fcsp_flash_ctrl.sv
/*
 * Register side of the flash controller: configuration, protection,
 * status and command registers, command sequencing and the one-deep
 * burst buffer in front of the array engine.
 * Assumes the array engine pulses op_done_in once per started operation,
 * and that CPU writes into the array space arrive on the array write port.
 */
// Overview of operation
// - Config bits 7:5 read/write, rest zero
// - Key window write starts command when disabled
// - Key window write is key write when enabled
// - Protection loaded from nonvolatile copy at reset
// - Software may only lower protect boundary
// - Protection disable set blocks software changes
// - Debug host may write protection freely
// - Boundary protects high addresses from program/erase
// - Disable bit zero protects, one protects nothing
// - Status bits 3,1,0 read zero
// - Buffer-empty cleared by launch, set by transfer
// - Only burst programs queue behind running command
// - Complete flag set when idle, cleared launch
// - Protected target sets violation, drops command
// - Access error on sequence, divider, stop
// - Blank flag set by passing blank check
// - Codes for blank check, byte, burst program
// - Codes for page and mass erase
// - Other codes raise access error
// - Program/erase locked until divider written once
// - Security code unsecured after key or blank
`timescale 1ns/1ps

module fcsp_flash_ctrl #(
    parameter int ADDR_W = 16
) (
    input  wire logic                 clock_in,
    input  wire logic                 nrst_in,
    input  wire logic                 psel_in,
    input  wire logic                 penable_in,
    input  wire logic                 pwrite_in,
    input  wire logic [7:0]           paddr_in,
    input  wire logic [31:0]          pwdata_in,
    output logic      [31:0]          prdata_out,
    output logic                      pready_out,
    output logic                      pslverr_out,
    input  wire logic                 array_wr_in,
    input  wire logic [ADDR_W-1:0]    array_addr_in,
    input  wire logic [7:0]           array_data_in,
    input  wire logic [7:0]           nv_protect_in,
    input  wire logic [1:0]           nv_security_in,
    input  wire logic                 debug_prot_wr_in,
    input  wire logic [7:0]           debug_prot_data_in,
    input  wire logic                 key_match_in,
    input  wire logic                 stop_in,
    input  wire logic                 op_done_in,
    input  wire logic                 op_blank_in,
    output fcsp_pkg::fcsp_op_t        op_out,
    output logic                      op_start_out,
    output logic                      op_abort_out,
    output logic                      key_wr_out,
    output logic      [7:0]           key_data_out,
    output logic      [7:0]           divider_out,
    output logic      [1:0]           security_state_code_out
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (ADDR_W != 16) begin : g_bad_width
        $error("fcsp_flash_ctrl: key window decode needs ADDR_W of 16");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0]          config_register;
    logic [7:0]          protection_register;
    logic [7:0]          command_code_register;
    logic [1:0]          security_state_code;
    logic                nv_loaded;
    logic                divider_loaded_flag;
    logic                protection_violation_flag;
    logic                access_error_flag;
    logic                blank_verified_flag;
    logic                buf_full;
    logic                busy;
    fcsp_pkg::fcsp_op_t  buf_op;
    fcsp_pkg::fcsp_op_t  seq_op;
    fcsp_pkg::fcsp_seq_t seq;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic       wr;
    logic       mapped;
    logic [7:0] wdat;
    logic       wr_status;
    logic       wr_command;
    logic       launch;
    logic       key_hit;
    logic       seq_wr;
    logic       cmd_legal;
    logic       cmd_needs_div;
    logic       target_prot;
    logic       launch_ok;
    logic       launch_err;
    logic       transfer;
    logic       stop_err;
    logic       seq_err;
    logic       command_buffer_empty_flag;
    logic       command_complete_flag;

    assign wr          = psel_in & penable_in & pwrite_in;
    assign wdat        = pwdata_in[7:0];
    assign pready_out  = 1'b1;
    assign mapped      = (paddr_in == fcsp_pkg::FCSP_OFS_DIVIDER)
                       | (paddr_in == fcsp_pkg::FCSP_OFS_SECURE)
                       | (paddr_in == fcsp_pkg::FCSP_OFS_CONFIG)
                       | (paddr_in == fcsp_pkg::FCSP_OFS_PROTECT)
                       | (paddr_in == fcsp_pkg::FCSP_OFS_STATUS)
                       | (paddr_in == fcsp_pkg::FCSP_OFS_COMMAND);
    assign pslverr_out = psel_in & penable_in & ~mapped;
    assign wr_status   = wr & (paddr_in == fcsp_pkg::FCSP_OFS_STATUS);
    assign wr_command  = wr & (paddr_in == fcsp_pkg::FCSP_OFS_COMMAND);
    assign launch      = wr_status & wdat[fcsp_pkg::FCSP_ST_BUF_EMPTY];

    // ------------------------------------------------------------
    // Command checks
    // ------------------------------------------------------------
    assign key_hit = array_wr_in & config_register[fcsp_pkg::FCSP_KEY_EN_BIT]
                   & (array_addr_in >= fcsp_pkg::FCSP_KEY_LO)
                   & (array_addr_in <= fcsp_pkg::FCSP_KEY_HI);
    assign seq_wr  = array_wr_in & ~key_hit;

    always_comb begin
        unique case (seq_op.code)
            fcsp_pkg::FCSP_CMD_BLANK,
            fcsp_pkg::FCSP_CMD_BYTE,
            fcsp_pkg::FCSP_CMD_BURST,
            fcsp_pkg::FCSP_CMD_PAGE,
            fcsp_pkg::FCSP_CMD_MASS:  cmd_legal = 1'b1;
            default:                  cmd_legal = 1'b0;
        endcase
    end

    assign cmd_needs_div = (seq_op.code != fcsp_pkg::FCSP_CMD_BLANK);

    // Protected region sits above the boundary page; mass erase touches it
    always_comb begin
        if (protection_register[0]) begin
            target_prot = 1'b0;
        end else if (seq_op.code == fcsp_pkg::FCSP_CMD_MASS) begin
            target_prot = 1'b1;
        end else if (seq_op.code == fcsp_pkg::FCSP_CMD_BLANK) begin
            target_prot = 1'b0;
        end else begin
            target_prot = seq_op.addr[15:fcsp_pkg::FCSP_PAGE_SHIFT]
                          > protection_register[7:1];
        end
    end

    // Non-burst commands may not stack behind work in flight
    assign launch_err = launch & ((seq != fcsp_pkg::FCSP_SEQ_CMD) | ~cmd_legal
                      | (cmd_needs_div & ~divider_loaded_flag)
                      | buf_full
                      | (busy & (seq_op.code != fcsp_pkg::FCSP_CMD_BURST)));
    assign launch_ok  = launch & ~launch_err & ~target_prot;
    assign transfer   = buf_full & ~busy & ~stop_in;
    assign stop_err   = stop_in & (busy | buf_full);
    assign seq_err    = (seq_wr & (seq != fcsp_pkg::FCSP_SEQ_IDLE))
                      | (wr_command & (seq != fcsp_pkg::FCSP_SEQ_DATA));

    assign command_buffer_empty_flag = ~buf_full;
    assign command_complete_flag     = ~buf_full & ~busy;

    // ------------------------------------------------------------
    // Configuration and divider
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            config_register <= fcsp_pkg::FCSP_RST_CONFIG;
        end else if (wr & (paddr_in == fcsp_pkg::FCSP_OFS_CONFIG)) begin
            config_register <= wdat & fcsp_pkg::FCSP_CONFIG_MASK;
        end
    end

    // Any write sets the divider loaded flag, whatever the value written; later writes still change the divider
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            divider_out         <= 8'h00;
            divider_loaded_flag <= 1'b0;
        end else if (wr & (paddr_in == fcsp_pkg::FCSP_OFS_DIVIDER)) begin
            divider_out         <= {1'b0, wdat[6:0]};
            divider_loaded_flag <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Protection and security
    // ------------------------------------------------------------
    // Nonvolatile copy is caught on the first edge after release
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            nv_loaded           <= 1'b0;
            protection_register <= fcsp_pkg::FCSP_RST_PROTECT;
        end else if (!nv_loaded) begin
            nv_loaded           <= 1'b1;
            protection_register <= nv_protect_in;
        end else if (debug_prot_wr_in) begin
            protection_register <= debug_prot_data_in;
        end else if (wr & (paddr_in == fcsp_pkg::FCSP_OFS_PROTECT)
                     & ~protection_register[0]
                     & (wdat[7:1] < protection_register[7:1])) begin
            protection_register <= {wdat[7:1], 1'b0};
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            security_state_code <= fcsp_pkg::FCSP_RST_SECURE;
        end else if (!nv_loaded) begin
            security_state_code <= nv_security_in;
        end else if (key_match_in | (op_done_in & busy & op_blank_in
                     & (op_out.code == fcsp_pkg::FCSP_CMD_BLANK))) begin
            security_state_code <= fcsp_pkg::FCSP_SEC_UNSECURE;
        end
    end

    assign security_state_code_out = security_state_code;

    // ------------------------------------------------------------
    // Command sequence
    // ------------------------------------------------------------
    // Any misstep drops the partial command and restarts the sequence
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            seq    <= fcsp_pkg::FCSP_SEQ_IDLE;
            seq_op <= '0;
        end else if (seq_err | launch | stop_err) begin
            seq <= fcsp_pkg::FCSP_SEQ_IDLE;
        end else if (seq_wr) begin
            seq         <= fcsp_pkg::FCSP_SEQ_DATA;
            seq_op.addr <= array_addr_in;
            seq_op.data <= array_data_in;
        end else if (wr_command) begin
            seq         <= fcsp_pkg::FCSP_SEQ_CMD;
            seq_op.code <= wdat;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            command_code_register <= 8'h00;
        end else if (wr_command) begin
            command_code_register <= wdat;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            key_wr_out   <= 1'b0;
            key_data_out <= 8'h00;
        end else begin
            key_wr_out <= key_hit;
            if (key_hit) begin
                key_data_out <= array_data_in;
            end
        end
    end

    // ------------------------------------------------------------
    // Buffer and execution
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            buf_full <= 1'b0;
            buf_op   <= '0;
        end else if (stop_err) begin
            buf_full <= 1'b0;
        end else if (launch_ok) begin
            buf_full <= 1'b1;
            buf_op   <= seq_op;
        end else if (transfer) begin
            buf_full <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy         <= 1'b0;
            op_out       <= '0;
            op_start_out <= 1'b0;
            op_abort_out <= 1'b0;
        end else begin
            op_start_out <= transfer;
            op_abort_out <= stop_err & busy;
            if (stop_err) begin
                busy <= 1'b0;
            end else if (transfer) begin
                busy   <= 1'b1;
                op_out <= buf_op;
            end else if (op_done_in) begin
                busy <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags: a set in the same cycle as a clear wins
    // ------------------------------------------------------------
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            protection_violation_flag <= 1'b0;
        end else if (launch & ~launch_err & target_prot) begin
            protection_violation_flag <= 1'b1;
        end else if (wr_status & wdat[fcsp_pkg::FCSP_ST_PROT_VIOL]) begin
            protection_violation_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            access_error_flag <= 1'b0;
        end else if (launch_err | stop_err | seq_err) begin
            access_error_flag <= 1'b1;
        end else if (wr_status & wdat[fcsp_pkg::FCSP_ST_ACC_ERR]) begin
            access_error_flag <= 1'b0;
        end
    end

    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            blank_verified_flag <= 1'b0;
        end else if (op_done_in & busy & ~stop_err & op_blank_in
                     & (op_out.code == fcsp_pkg::FCSP_CMD_BLANK)) begin
            blank_verified_flag <= 1'b1;
        end else if (launch_ok) begin
            blank_verified_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_comb begin
        prdata_out = 32'h0000_0000;
        if (psel_in & ~pwrite_in) begin
            unique case (paddr_in)
                fcsp_pkg::FCSP_OFS_DIVIDER: prdata_out[7:0] =
                    {divider_loaded_flag, divider_out[6:0]};
                fcsp_pkg::FCSP_OFS_SECURE:  prdata_out[1:0] = security_state_code;
                fcsp_pkg::FCSP_OFS_CONFIG:  prdata_out[7:0] = config_register;
                fcsp_pkg::FCSP_OFS_PROTECT: prdata_out[7:0] = protection_register;
                fcsp_pkg::FCSP_OFS_STATUS:  prdata_out[7:0] =
                    {command_buffer_empty_flag, command_complete_flag,
                     protection_violation_flag, access_error_flag,
                     1'b0, blank_verified_flag, 2'b00};
                fcsp_pkg::FCSP_OFS_COMMAND: prdata_out[7:0] = command_code_register;
                default:                    prdata_out = 32'h0000_0000;
            endcase
        end
    end

endmodule

// >>> verification/fcsp_flash_ctrl_asserts.sv
/* Concurrent checks on the ports of fcsp_flash_ctrl.
   Assumes the register offsets and field layout of fcsp_pkg. */
`timescale 1ns/1ps
module fcsp_chk #(parameter int ADDR_W = 16) (
    input logic                  clock_in,
    input logic                  nrst_in,
    input logic                  psel_in,
    input logic                  penable_in,
    input logic                  pwrite_in,
    input logic [7:0]            paddr_in,
    input logic [31:0]           pwdata_in,
    input logic [31:0]           prdata_out,
    input logic                  pready_out,
    input logic                  array_wr_in,
    input logic [ADDR_W-1:0]     array_addr_in,
    input logic [7:0]            array_data_in,
    input logic [7:0]            nv_protect_in,
    input logic                  debug_prot_wr_in,
    input logic [7:0]            debug_prot_data_in,
    input logic                  key_match_in,
    input logic                  stop_in,
    input fcsp_pkg::fcsp_op_t    op_out,
    input logic                  op_start_out,
    input logic                  op_abort_out,
    input logic                  key_wr_out,
    input logic [7:0]            key_data_out,
    input logic [1:0]            security_state_code_out
);
    // ------------------------------------------------------------
    // Shadow registers
    // ------------------------------------------------------------
    logic       acc;
    logic       ld;
    logic       div_seen;
    logic [7:0] cfg_m;
    logic [7:0] prot_m;
    assign acc = psel_in && penable_in && pready_out;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            ld <= 1'b0;
            div_seen <= 1'b0;
            cfg_m <= 8'h00;
            prot_m <= 8'hff;
        end else begin
            ld <= 1'b1;
            if (acc && pwrite_in && paddr_in == 8'h00) div_seen <= 1'b1;
            if (acc && pwrite_in && paddr_in == 8'h08) cfg_m <= pwdata_in[7:0] & 8'he0;
            // Software may only shrink the boundary, and only while protection is on
            if (!ld) prot_m <= nv_protect_in;
            else if (debug_prot_wr_in) prot_m <= debug_prot_data_in;
            else if (acc && pwrite_in && paddr_in == 8'h0c && !prot_m[0]
                     && pwdata_in[7:1] < prot_m[7:1]) prot_m <= {pwdata_in[7:1], 1'b0};
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_cfg_read_back: assert property (acc && !pwrite_in && paddr_in == 8'h08
        |-> prdata_out == {24'h0, cfg_m}) else $error("config read mismatch");
    a_stat_unused_zero: assert property (acc && !pwrite_in && paddr_in == 8'h10
        |-> prdata_out[3] == 1'b0 && prdata_out[1:0] == 2'b00) else $error("status spare bits");
    a_prot_shadow: assert property (acc && !pwrite_in && paddr_in == 8'h0c
        |-> prdata_out[7:0] == prot_m) else $error("protection value mismatch");
    a_div_flag: assert property (acc && !pwrite_in && paddr_in == 8'h00
        |-> prdata_out[7] == div_seen) else $error("divider flag mismatch");
    a_key_window: assert property (array_wr_in && cfg_m[5] && array_addr_in >= 16'hffb0
        && array_addr_in <= 16'hffb7 |=> key_wr_out && key_data_out == $past(array_data_in))
        else $error("key write not passed on");
    a_key_off: assert property (array_wr_in && !cfg_m[5] |=> !key_wr_out)
        else $error("key write while disabled");
    a_start_code: assert property (op_start_out |-> op_out.code inside
        {8'h05, 8'h20, 8'h25, 8'h40, 8'h41}) else $error("illegal code started");
    a_abort_stop: assert property (op_abort_out |-> $past(stop_in))
        else $error("abort without stop");
    a_key_unsecure: assert property (key_match_in |=> security_state_code_out == 2'b10)
        else $error("security not released");
endmodule

bind fcsp_flash_ctrl fcsp_chk #(.ADDR_W(ADDR_W)) i_chk (.clock_in, .nrst_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .array_wr_in,
    .array_addr_in, .array_data_in, .nv_protect_in, .debug_prot_wr_in, .debug_prot_data_in,
    .key_match_in, .stop_in, .op_out, .op_start_out, .op_abort_out, .key_wr_out,
    .key_data_out, .security_state_code_out);

// >>> verification/tb_top.sv
/* Directed bench for fcsp_flash_ctrl: APB master, array writes, engine.
   Assumes the checker is bound on its own. */
`timescale 1ns/1ps
module tb_top;
    logic clock_in = 1'b0, nrst_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0;
    logic pwrite_in = 1'b0, op_blank_in = 1'b0;
    logic [4:0] pl = 5'h00;
    wire array_wr_in = pl[0], debug_prot_wr_in = pl[1], key_match_in = pl[2];
    wire stop_in = pl[3], op_done_in = pl[4];
    logic [7:0]  paddr_in = 8'h00, array_data_in = 8'h00, debug_prot_data_in = 8'h00;
    logic [7:0]  nv_protect_in = 8'hc0;
    logic [1:0]  nv_security_in = 2'h3;
    logic [15:0] array_addr_in = 16'h0000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic pready_out, pslverr_out, op_start_out, op_abort_out, key_wr_out, err;
    logic [7:0] key_data_out, divider_out;
    logic [1:0] security_state_code_out;
    fcsp_pkg::fcsp_op_t op_out;
    logic [7:0] codes [5] = '{8'h05, 8'h20, 8'h25, 8'h40, 8'h41};
    int error_cnt = 0, n_tests = 0, cyc = 0;
    always #5 clock_in = ~clock_in;
    fcsp_flash_ctrl i_dut (.clock_in, .nrst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
        .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .array_wr_in, .array_addr_in,
        .array_data_in, .nv_protect_in, .nv_security_in, .debug_prot_wr_in,
        .debug_prot_data_in, .key_match_in, .stop_in, .op_done_in, .op_blank_in, .op_out,
        .op_start_out, .op_abort_out, .key_wr_out, .key_data_out, .divider_out,
        .security_state_code_out);

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge clock_in) begin
        cyc++;
        // Generous ceiling: the directed run needs well under a thousand cycles
        if (cyc == 5000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clock_in);
        penable_in <= 1'b1;
        do @(posedge clock_in); while (pready_out !== 1'b1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask
    task automatic pulse(input int k);
        @(posedge clock_in);
        pl <= 5'h01 << k;
        @(posedge clock_in);
        pl <= 5'h00;
    endtask
    task automatic seq(input logic [15:0] a, input logic [7:0] code);
        array_addr_in <= a;
        array_data_in <= 8'h5a;
        pulse(0);
        apb(1'b1, 8'h14, {24'h0, code});
        apb(1'b1, 8'h10, 32'h80);
    endtask
    task automatic done(input logic blank);
        op_blank_in <= blank;
        pulse(4);
    endtask
    task automatic wait_start();
        int n = 0;
        do begin
            @(posedge clock_in);
            n++;
        end while (op_start_out !== 1'b1 && n < 50);
        chk("start pulse", 32'h1, {31'h0, op_start_out});
    endtask
    task automatic dprot(input logic [7:0] v);
        debug_prot_data_in <= v;
        pulse(1);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rdc(8'h10, 32'hc0, "status");
        rdc(8'h0c, 32'hc0, "protection");
        apb(1'b1, 8'h08, 32'hffffffff);
        rdc(8'h08, 32'he0, "config");
        apb(1'b1, 8'h10, 32'h0b);
        rdc(8'h10, 32'hc0, "status");
        apb(1'b1, 8'h0c, 32'hd0);
        rdc(8'h0c, 32'hc0, "protection");
        apb(1'b1, 8'h0c, 32'h80);
        rdc(8'h0c, 32'h80, "protection");
        dprot(8'h81);
        rdc(8'h0c, 32'h81, "protection");
        apb(1'b1, 8'h0c, 32'h40);
        rdc(8'h0c, 32'h81, "protection");
        rdc(8'h18, 32'h0, "unmapped");
        chk("slave error", 32'h1, {31'h0, err});
        array_addr_in <= 16'hffb3;
        array_data_in <= 8'h77;
        pulse(0);
        pulse(2);
        @(posedge clock_in);
        chk("security", 32'h2, {30'h0, security_state_code_out});
        apb(1'b1, 8'h08, 32'h0);
        $display("register test done");
    endtask
    task automatic t_err();
        seq(16'h1000, 8'h20);
        rdc(8'h10, 32'hd0, "status");
        apb(1'b1, 8'h10, 32'h10);
        rdc(8'h10, 32'hc0, "status");
        apb(1'b1, 8'h00, 32'h0a);
        rdc(8'h00, 32'h8a, "divider");
        chk("divider port", 32'h0a, {24'h0, divider_out});
        seq(16'h1000, 8'h33);
        rdc(8'h10, 32'hd0, "status");
        apb(1'b1, 8'h10, 32'h10);
        apb(1'b1, 8'h14, 32'h20);
        rdc(8'h10, 32'hd0, "status");
        apb(1'b1, 8'h10, 32'h10);
        $display("error test done");
    endtask
    task automatic t_cmds();
        foreach (codes[i]) begin
            seq(16'hffb0, codes[i]);
            wait_start();
            chk("op", {codes[i], 16'hffb0, 8'h5a}, op_out);
            rdc(8'h10, 32'h80, "status");
            done(codes[i] == 8'h05);
            rdc(8'h10, (codes[i] == 8'h05) ? 32'hc4 : 32'hc0, "status");
        end
        $display("command test done");
    endtask
    task automatic t_burst();
        seq(16'h0100, 8'h25);
        wait_start();
        seq(16'h0101, 8'h25);
        rdc(8'h10, 32'h00, "status");
        done(1'b0);
        wait_start();
        chk("op address", 32'h0101, {16'h0, op_out.addr});
        done(1'b0);
        rdc(8'h10, 32'hc0, "status");
        $display("burst test done");
    endtask
    task automatic t_prot_stop();
        dprot(8'h40);
        seq(16'hffb0, 8'h20);
        rdc(8'h10, 32'he0, "status");
        apb(1'b1, 8'h10, 32'h20);
        rdc(8'h10, 32'hc0, "status");
        seq(16'h2000, 8'h20);
        wait_start();
        pulse(3);
        apb(1'b0, 8'h10, 32'h0);
        chk("error flag", 32'h10, rd & 32'h10);
        $display("protection and stop test done");
    endtask

    initial begin
        repeat (20) @(posedge clock_in);
        nrst_in <= 1'b1;
        @(posedge clock_in);
        t_regs();
        t_err();
        t_cmds();
        t_burst();
        t_prot_stop();
        report_and_stop();
    end
endmodule
